// ### src/ssu_ctrl.sv
// Serial shift unit: control register, clocking, shift register, counter and pin drive
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
// What this block does
// - Start interrupt raised while start enable, pending start flag and global enable.
// - Overflow interrupt raised while overflow enable, pending flag and global enable.
// - Wire mode changes only outputs and start detection; data and clock inputs always work.
// - Mode zero: outputs, clock hold and start detector off; pins plain.
// - Three-wire: shift output overrides port bit; direction bit still rules.
// - Two-wire: data line pulled low, with direction bit set, if shift output or port bit zero.
// - Two-wire: clock pulled low, with direction bit set, by port bit zero or start hold.
// - Two-wire modes: no serial data or clock pull-ups, open-drain data and clock drivers.
// - Mode 11 also holds clock low after overflow until flag cleared.
// - Internal clocks make output latch transparent; external changes on opposite edge.
// - Select 00 strobe off: no clock; strobe: software; 01: timer match.
// - External: 10 shifts rising, 11 falling; counter counts both edges.
// - Software strobe shifts and counts once, output follows, bit reads zero.
// - Software strobe shifts in data input sampled one cycle earlier.
// - External with strobe bit set: counter clocked only by toggle writes.
// - Toggle write inverts clock port bit regardless of direction; reads zero.
// - Toggle write under external strobe select increments the counter directly.
// - Start flag cleared only by writing one; clearing releases clock hold.
// - Overflow flag set on counter wrap 15 to 0; cleared by writing one.
// - Three-wire: data output pin driven through latch from shift register top bit; other modes drive the port bit.
module ssu_ctrl
   import ssu_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   // Register port
   input wire logic [SSU_ADDR_W-1:0] addr_i,
   input wire logic [SSU_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [SSU_DATA_W-1:0] rdata_o,
   // System side
   input wire logic global_irq_enable_i,
   input wire logic timer_match_i,
   output logic start_irq_o,
   output logic overflow_irq_o,
   // Three-wire data output pin
   output logic data_out_pin_o,
   output logic data_out_pin_oe_o,
   output logic data_out_pullup_o,
   // Serial data pin (data in / two-wire data)
   input wire logic serial_in_pin_i,
   output logic serial_in_pin_o,
   output logic serial_in_pin_oe_o,
   output logic serial_in_pullup_o,
   // Serial clock pin
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   output logic serial_clock_pullup_o
);

   // Register state
   logic [7:0] ctrl_ff;
   logic [7:0] shift_ff;
   logic [3:0] count_ff;
   logic start_flag_ff;
   logic overflow_flag_ff;
   logic [5:0] port_ff;
   logic do_latch_ff;
   logic [7:0] rdata_ff;

   // Pin synchronisers and history
   logic di_s1_ff;
   logic di_s2_ff;
   logic di_prev_ff;
   logic ck_s1_ff;
   logic ck_s2_ff;
   logic ck_prev_ff;

   // Next values
   logic [7:0] nxt_ctrl;
   logic [7:0] nxt_shift;
   logic [3:0] nxt_count;
   logic nxt_start_flag;
   logic nxt_overflow_flag;
   logic [5:0] nxt_port;
   logic nxt_do_latch;
   logic [7:0] nxt_rdata;

   // Field views of the control register
   wire start_ie = ctrl_ff[SSU_CTRL_START_IE];
   wire ovf_ie = ctrl_ff[SSU_CTRL_OVF_IE];
   wire [1:0] wire_mode_select = ctrl_ff[SSU_CTRL_WM_HI:SSU_CTRL_WM_LO];
   wire [1:0] clock_source_select = ctrl_ff[SSU_CTRL_CS_HI:SSU_CTRL_CS_LO];
   wire strobe_select = ctrl_ff[SSU_CTRL_STROBE];
   wire ext_clock = clock_source_select[1];
   wire two_wire = wire_mode_select[1];

   // Bus decode
   wire wr_ctrl = wr_i && (addr_i == SSU_IDX_CTRL);
   wire wr_data = wr_i && (addr_i == SSU_IDX_DATA);
   wire wr_stat = wr_i && (addr_i == SSU_IDX_STAT);
   wire wr_port = wr_i && (addr_i == SSU_IDX_PORT);
   wire software_strobe = wr_ctrl && wdata_i[SSU_CTRL_STROBE];
   wire clock_pin_toggle = wr_ctrl && wdata_i[SSU_CTRL_TOGGLE];

   // Synchronised clock and data pin edges, taken from the second stage only
   wire ck_rise = ck_s2_ff && !ck_prev_ff;
   wire ck_fall = !ck_s2_ff && ck_prev_ff;
   wire ck_edge = ck_rise || ck_fall;
   wire sda_fall = !di_s2_ff && di_prev_ff;

   // Shift clock selection; strobe writes take effect under the mode in force before the write
   wire soft_sel = (clock_source_select == SSU_CS_SOFT);
   wire tmr_sel = (clock_source_select == SSU_CS_TIMER);
   wire ext_shift_edge = clock_source_select[0] ? ck_fall : ck_rise;
   wire shift_soft = soft_sel && software_strobe;
   wire shift_tmr = tmr_sel && timer_match_i;
   wire shift_ext = ext_clock && ext_shift_edge;
   wire shift_evt = shift_soft || shift_tmr || shift_ext;

   // Counter clock: external both edges unless the strobe bit picks toggle writes
   wire count_ext = ext_clock && !strobe_select && ck_edge;
   wire count_tog = ext_clock && strobe_select && clock_pin_toggle;
   wire count_evt = shift_soft || shift_tmr || count_ext || count_tog;

   // Input bit: software strobe uses the sample from the cycle before
   wire shift_in_bit = shift_soft ? di_prev_ff : di_s2_ff;

   // Output latch open all the time on internal clocks, during the first half of a cycle otherwise
   wire latch_open = !ext_clock || (clock_source_select[0] ? ck_s2_ff : !ck_s2_ff);
   wire do_value = latch_open ? shift_ff[SSU_DATA_W-1] : do_latch_ff;

   // Start detector only lives in two-wire modes
   wire start_evt = two_wire && sda_fall && ck_s2_ff;
   wire count_wrap = count_evt && (count_ff == SSU_CNT_MAX);

   // Clock hold sources
   wire hold_start = two_wire && start_flag_ff;
   wire hold_ovf = (wire_mode_select == SSU_WM_TWO_OVF) && overflow_flag_ff;
   wire scl_hold = hold_start || hold_ovf;

   // Port register views
   wire do_port = port_ff[SSU_PORT_DO_VAL];
   wire do_dir = port_ff[SSU_PORT_DO_DIR];
   wire sda_port = port_ff[SSU_PORT_SDA_VAL];
   wire sda_dir = port_ff[SSU_PORT_SDA_DIR];
   wire scl_port = port_ff[SSU_PORT_SCL_VAL];
   wire scl_dir = port_ff[SSU_PORT_SCL_DIR];

   // Control register: toggle bit never stored, strobe bit kept only with external clocks; both read zero
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = wdata_i;
         nxt_ctrl[SSU_CTRL_TOGGLE] = 1'b0;
         if (!wdata_i[SSU_CTRL_CS_HI]) begin
            nxt_ctrl[SSU_CTRL_STROBE] = 1'b0;
         end
      end
   end

   // Shift register: a software write wins over a shift in the same cycle
   always_comb begin
      nxt_shift = shift_ff;
      if (wr_data) begin
         nxt_shift = wdata_i;
      end else if (shift_evt) begin
         nxt_shift = {shift_ff[SSU_DATA_W-2:0], shift_in_bit};
      end
   end

   // Counter: written value wins over a count in the same cycle
   always_comb begin
      nxt_count = count_ff;
      if (wr_stat) begin
         nxt_count = wdata_i[SSU_STAT_CNT_HI:0];
      end else if (count_evt) begin
         nxt_count = count_ff + SSU_CNT_ONE;
      end
   end

   // Flags: start set wins over a write-one clear in the same cycle; any status write blocks the overflow set
   always_comb begin
      nxt_start_flag = start_flag_ff;
      nxt_overflow_flag = overflow_flag_ff;
      if (wr_stat && wdata_i[SSU_STAT_START]) begin
         nxt_start_flag = 1'b0;
      end
      if (wr_stat && wdata_i[SSU_STAT_OVF]) begin
         nxt_overflow_flag = 1'b0;
      end
      if (start_evt) begin
         nxt_start_flag = 1'b1;
      end
      if (count_wrap && !wr_stat) begin
         nxt_overflow_flag = 1'b1;
      end
   end

   // Port bits: toggle write inverts the clock port bit whatever its direction
   always_comb begin
      nxt_port = port_ff;
      if (wr_port) begin
         nxt_port = wdata_i[SSU_PORT_SCL_DIR:0];
      end
      if (clock_pin_toggle) begin
         nxt_port[SSU_PORT_SCL_VAL] = !port_ff[SSU_PORT_SCL_VAL];
      end
   end

   // Latch follows the top bit while open and holds it while closed
   assign nxt_do_latch = do_value;

   // Read mux; unmapped addresses cannot occur with a two-bit index
   always_comb begin
      nxt_rdata = rdata_ff;
      if (rd_i) begin
         unique case (addr_i)
            SSU_IDX_CTRL: nxt_rdata = {ctrl_ff[SSU_CTRL_START_IE:SSU_CTRL_CS_LO], 2'h0};
            SSU_IDX_DATA: nxt_rdata = shift_ff;
            SSU_IDX_STAT: nxt_rdata = {start_flag_ff, overflow_flag_ff, 2'h0, count_ff};
            SSU_IDX_PORT: nxt_rdata = {2'h0, port_ff};
         endcase
      end
   end

   // Synchronisers for both pins, active in every wire mode
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         di_s1_ff <= 1'b1;
         di_s2_ff <= 1'b1;
         di_prev_ff <= 1'b1;
         ck_s1_ff <= 1'b1;
         ck_s2_ff <= 1'b1;
         ck_prev_ff <= 1'b1;
      end else begin
         di_s1_ff <= serial_in_pin_i;
         di_s2_ff <= di_s1_ff;
         di_prev_ff <= di_s2_ff;
         ck_s1_ff <= serial_clock_pin_i;
         ck_s2_ff <= ck_s1_ff;
         ck_prev_ff <= ck_s2_ff;
      end
   end

   // Register update
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_ff <= SSU_CTRL_RST;
         shift_ff <= SSU_DATA_RST;
         count_ff <= SSU_CNT_RST;
         start_flag_ff <= 1'b0;
         overflow_flag_ff <= 1'b0;
         port_ff <= SSU_PORT_RST;
         do_latch_ff <= 1'b0;
         rdata_ff <= SSU_DATA_RST;
      end else begin
         ctrl_ff <= nxt_ctrl;
         shift_ff <= nxt_shift;
         count_ff <= nxt_count;
         start_flag_ff <= nxt_start_flag;
         overflow_flag_ff <= nxt_overflow_flag;
         port_ff <= nxt_port;
         do_latch_ff <= nxt_do_latch;
         rdata_ff <= nxt_rdata;
      end
   end

   // Interrupt requests; a flag pending when the enables come up fires at once
   assign start_irq_o = start_ie && start_flag_ff && global_irq_enable_i;
   assign overflow_irq_o = ovf_ie && overflow_flag_ff && global_irq_enable_i;
   assign rdata_o = rdata_ff;

   // Data output pin: shift output overrides the port bit only in three-wire mode
   assign data_out_pin_o = (wire_mode_select == SSU_WM_THREE) ? do_value : do_port;
   assign data_out_pin_oe_o = do_dir;
   assign data_out_pullup_o = !do_dir && do_port;

   // Data pin: open drain in two-wire modes, plain port otherwise
   assign serial_in_pin_o = two_wire ? 1'b0 : sda_port;
   assign serial_in_pin_oe_o = two_wire ? (sda_dir && (!do_value || !sda_port)) : sda_dir;
   assign serial_in_pullup_o = !two_wire && !sda_dir && sda_port;

   // Clock pin: hold only pulls low when the driver is enabled by direction
   assign serial_clock_pin_o = two_wire ? 1'b0 : scl_port;
   assign serial_clock_pin_oe_o = two_wire ? (scl_dir && (!scl_port || scl_hold)) : scl_dir;
   assign serial_clock_pullup_o = !two_wire && !scl_dir && scl_port;

endmodule

// ### src/ssu_pkg.sv
// Constants shared by the serial shift unit control block
package ssu_pkg;
   // Register bus geometry
   localparam int unsigned SSU_ADDR_W = 2;
   localparam int unsigned SSU_DATA_W = 8;

   // Register indices on the plain register port
   localparam logic [1:0] SSU_IDX_CTRL = 2'h0;
   localparam logic [1:0] SSU_IDX_DATA = 2'h1;
   localparam logic [1:0] SSU_IDX_STAT = 2'h2;
   localparam logic [1:0] SSU_IDX_PORT = 2'h3;

   // Control register fields
   localparam int unsigned SSU_CTRL_START_IE = 7;
   localparam int unsigned SSU_CTRL_OVF_IE = 6;
   localparam int unsigned SSU_CTRL_WM_HI = 5;
   localparam int unsigned SSU_CTRL_WM_LO = 4;
   localparam int unsigned SSU_CTRL_CS_HI = 3;
   localparam int unsigned SSU_CTRL_CS_LO = 2;
   localparam int unsigned SSU_CTRL_STROBE = 1;
   localparam int unsigned SSU_CTRL_TOGGLE = 0;

   // Status register fields
   localparam int unsigned SSU_STAT_START = 7;
   localparam int unsigned SSU_STAT_OVF = 6;
   localparam int unsigned SSU_STAT_CNT_HI = 3;

   // Pin port register fields
   localparam int unsigned SSU_PORT_DO_VAL = 0;
   localparam int unsigned SSU_PORT_DO_DIR = 1;
   localparam int unsigned SSU_PORT_SDA_VAL = 2;
   localparam int unsigned SSU_PORT_SDA_DIR = 3;
   localparam int unsigned SSU_PORT_SCL_VAL = 4;
   localparam int unsigned SSU_PORT_SCL_DIR = 5;

   // Wire modes
   localparam logic [1:0] SSU_WM_OFF = 2'h0;
   localparam logic [1:0] SSU_WM_THREE = 2'h1;
   localparam logic [1:0] SSU_WM_TWO = 2'h2;
   localparam logic [1:0] SSU_WM_TWO_OVF = 2'h3;

   // Clock source selections
   localparam logic [1:0] SSU_CS_SOFT = 2'h0;
   localparam logic [1:0] SSU_CS_TIMER = 2'h1;

   // Reset values and counter constants
   localparam logic [7:0] SSU_CTRL_RST = 8'h00;
   localparam logic [7:0] SSU_DATA_RST = 8'h00;
   localparam logic [5:0] SSU_PORT_RST = 6'h00;
   localparam logic [3:0] SSU_CNT_RST = 4'h0;
   localparam logic [3:0] SSU_CNT_MAX = 4'hf;
   localparam logic [3:0] SSU_CNT_ONE = 4'h1;
endpackage

// ### test/ssu_ctrl_monitor.sv
// Port checker for the serial shift unit control block
`timescale 1ns/100ps
module ssu_ctrl_monitor
   import ssu_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [SSU_ADDR_W-1:0] addr_i,
   input wire logic [SSU_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [SSU_DATA_W-1:0] rdata_o,
   input wire logic global_irq_enable_i,
   input wire logic start_irq_o,
   input wire logic overflow_irq_o,
   input wire logic data_out_pin_o,
   input wire logic data_out_pin_oe_o,
   input wire logic serial_in_pin_o,
   input wire logic serial_in_pin_oe_o,
   input wire logic serial_in_pullup_o,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe_o,
   input wire logic serial_clock_pullup_o
);
   logic [7:0] ctrl_ff;
   logic [1:0] port_ff;
   // Shadow of software settings, updated at the same edge as the block's own registers
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_ff <= 8'h00;
         port_ff <= 2'h0;
      end else if (wr_i && addr_i == SSU_IDX_CTRL) begin
         ctrl_ff <= wdata_i;
      end else if (wr_i && addr_i == SSU_IDX_PORT) begin
         port_ff <= wdata_i[1:0];
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_rd_ctrl;
      rd_i && addr_i == SSU_IDX_CTRL;
   endsequence
   sequence s_rd_stat;
      rd_i && addr_i == SSU_IDX_STAT;
   endsequence
   start_gate_a: assert property (start_irq_o |-> global_irq_enable_i && ctrl_ff[7])
      else $error("start irq without its enables");
   ovf_gate_a: assert property (overflow_irq_o |-> global_irq_enable_i && ctrl_ff[6])
      else $error("overflow irq without its enables");
   start_read_a: assert property (s_rd_stat ##0 start_irq_o |=> rdata_o[7])
      else $error("start irq with no pending flag");
   ovf_read_a: assert property (s_rd_stat ##0 overflow_irq_o |=> rdata_o[6])
      else $error("overflow irq with no pending flag");
   toggle_reads_a: assert property (s_rd_ctrl |=> !rdata_o[0])
      else $error("toggle bit read as one");
   strobe_reads_a: assert property (s_rd_ctrl |=> !rdata_o[1])
      else $error("strobe bit read as one");
   two_wire_pull_a: assert property (ctrl_ff[5] |-> !serial_in_pullup_o && !serial_clock_pullup_o)
      else $error("pull-up on in two-wire mode");
   open_drain_a: assert property (ctrl_ff[5] |-> !(serial_in_pin_oe_o && serial_in_pin_o)
      && !(serial_clock_pin_oe_o && serial_clock_pin_o)) else $error("two-wire line driven high");
   mode_off_a: assert property (ctrl_ff[5:4] == SSU_WM_OFF |-> data_out_pin_o == port_ff[0]
      && data_out_pin_oe_o == port_ff[1]) else $error("data pin not plain in mode off");
endmodule
bind ssu_ctrl ssu_ctrl_monitor i_ssu_ctrl_monitor (
   .clock_i(clock_i),
   .rst_i(rst_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .global_irq_enable_i(global_irq_enable_i),
   .start_irq_o(start_irq_o),
   .overflow_irq_o(overflow_irq_o),
   .data_out_pin_o(data_out_pin_o),
   .data_out_pin_oe_o(data_out_pin_oe_o),
   .serial_in_pin_o(serial_in_pin_o),
   .serial_in_pin_oe_o(serial_in_pin_oe_o),
   .serial_in_pullup_o(serial_in_pullup_o),
   .serial_clock_pin_o(serial_clock_pin_o),
   .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
   .serial_clock_pullup_o(serial_clock_pullup_o)
);

// ### test/ssu_ctrl_tb_top.sv
// Self-checking bench for the serial shift unit control block
`timescale 1ns/100ps
module ssu_ctrl_tb_top;
   import ssu_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] addr_i = 2'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic global_irq_enable_i = 1'b1;
   logic timer_match_i = 1'b0;
   logic [7:0] rdata_o;
   logic start_irq_o, overflow_irq_o, data_out_pin_o, data_out_pin_oe_o, data_out_pullup_o;
   logic serial_in_pin_i, serial_in_pin_o, serial_in_pin_oe_o, serial_in_pullup_o;
   logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_o, serial_clock_pullup_o;
   int num_errors = 0;
   int n_tests = 0;
   ssu_ctrl i_ssu_ctrl (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .global_irq_enable_i(global_irq_enable_i),
      .timer_match_i(timer_match_i),
      .start_irq_o(start_irq_o),
      .overflow_irq_o(overflow_irq_o),
      .data_out_pin_o(data_out_pin_o),
      .data_out_pin_oe_o(data_out_pin_oe_o),
      .data_out_pullup_o(data_out_pullup_o),
      .serial_in_pin_i(serial_in_pin_i),
      .serial_in_pin_o(serial_in_pin_o),
      .serial_in_pin_oe_o(serial_in_pin_oe_o),
      .serial_in_pullup_o(serial_in_pullup_o),
      .serial_clock_pin_i(serial_clock_pin_i),
      .serial_clock_pin_o(serial_clock_pin_o),
      .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
      .serial_clock_pullup_o(serial_clock_pullup_o)
   );
   ssu_peer i_ssu_peer (.sda_oe_i(serial_in_pin_oe_o), .sda_out_i(serial_in_pin_o),
      .scl_oe_i(serial_clock_pin_oe_o), .scl_out_i(serial_clock_pin_o),
      .sda_line_o(serial_in_pin_i), .scl_line_o(serial_clock_pin_i));
   // 100 MHz system clock
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus cycles start after a rising edge and end at a falling edge, where outputs have settled
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      @(negedge clock_i);
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(negedge clock_i);
      v = rdata_o;
   endtask
   task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(v, e);
   endtask
   task automatic tick;
      @(posedge clock_i);
      timer_match_i <= 1'b1;
      @(posedge clock_i);
      timer_match_i <= 1'b0;
      @(negedge clock_i);
   endtask
   // A hang ends the run as a failure
   initial begin
      #500000;
      num_errors++;
      print_verdict();
   end
   // Main sequence
   initial begin
      logic [7:0] v;
      int k;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      rdchk(SSU_IDX_CTRL, 8'h00);
      wr(SSU_IDX_PORT, 8'h01);
      chk({6'h0, data_out_pullup_o, data_out_pin_oe_o}, 8'h02);
      wr(SSU_IDX_PORT, 8'h02);
      wr(SSU_IDX_CTRL, 8'h10);
      wr(SSU_IDX_DATA, 8'h80);
      chk({6'h0, data_out_pin_oe_o, data_out_pin_o}, 8'h03);
      wr(SSU_IDX_CTRL, 8'h12);
      chk({7'h0, data_out_pin_o}, 8'h00);
      rdchk(SSU_IDX_DATA, 8'h01);
      rdchk(SSU_IDX_STAT, 8'h01);
      rdchk(SSU_IDX_CTRL, 8'h10);
      $display("software strobe test done");
      wr(SSU_IDX_CTRL, 8'h14);
      tick();
      rdchk(SSU_IDX_DATA, 8'h03);
      wr(SSU_IDX_CTRL, 8'h10);
      tick();
      rdchk(SSU_IDX_STAT, 8'h02);
      $display("timer clock test done");
      wr(SSU_IDX_STAT, 8'h0f);
      wr(SSU_IDX_CTRL, 8'h52);
      chk({6'h0, overflow_irq_o, start_irq_o}, 8'h02);
      rdchk(SSU_IDX_STAT, 8'h40);
      @(posedge clock_i);
      global_irq_enable_i <= 1'b0;
      @(negedge clock_i);
      chk({7'h0, overflow_irq_o}, 8'h00);
      wr(SSU_IDX_STAT, 8'h40);
      rdchk(SSU_IDX_STAT, 8'h00);
      @(posedge clock_i);
      global_irq_enable_i <= 1'b1;
      $display("overflow test done");
      wr(SSU_IDX_CTRL, 8'h0a);
      wr(SSU_IDX_STAT, 8'h00);
      wr(SSU_IDX_CTRL, 8'h0b);
      rdchk(SSU_IDX_PORT, 8'h12);
      rdchk(SSU_IDX_STAT, 8'h01);
      rdchk(SSU_IDX_CTRL, 8'h08);
      $display("toggle test done");
      // Outputs off, clock pin driven from its port bit: toggles make falling then rising pin edges
      wr(SSU_IDX_CTRL, 8'h0c);
      wr(SSU_IDX_PORT, 8'h30);
      wr(SSU_IDX_DATA, 8'h00);
      wr(SSU_IDX_STAT, 8'h00);
      wr(SSU_IDX_CTRL, 8'h0d);
      wr(SSU_IDX_CTRL, 8'h0d);
      repeat (4) @(negedge clock_i);
      rdchk(SSU_IDX_DATA, 8'h01);
      rdchk(SSU_IDX_STAT, 8'h02);
      $display("falling edge test done");
      // Load the shift register while the latch is open so two-wire entry does not pull data low
      wr(SSU_IDX_PORT, 8'h3c);
      wr(SSU_IDX_CTRL, 8'h00);
      wr(SSU_IDX_DATA, 8'hff);
      wr(SSU_IDX_CTRL, 8'hf8);
      wr(SSU_IDX_STAT, 8'h00);
      fork
         i_ssu_peer.send(8'ha5);
         begin
            k = 0;
            v = 8'h00;
            while (!v[7] && k < 100) begin
               rd(SSU_IDX_STAT, v);
               k++;
            end
            chk({7'h0, v[7]}, 8'h01);
            repeat (20) @(negedge clock_i);
            chk({6'h0, start_irq_o, serial_clock_pin_i}, 8'h02);
            wr(SSU_IDX_STAT, 8'h80);
         end
      join
      repeat (20) @(negedge clock_i);
      chk({5'h0, overflow_irq_o, start_irq_o, serial_clock_pin_i}, 8'h04);
      rdchk(SSU_IDX_STAT, 8'h40);
      rdchk(SSU_IDX_DATA, 8'ha5);
      wr(SSU_IDX_STAT, 8'h40);
      chk({7'h0, serial_clock_pin_i}, 8'h01);
      $display("two-wire receive test done");
      print_verdict();
   end
endmodule

// ### test/ssu_peer.sv
// Behavioural two-wire bus master facing the serial shift unit
`timescale 1ns/100ps
module ssu_peer (
   input wire logic sda_oe_i,
   input wire logic sda_out_i,
   input wire logic scl_oe_i,
   input wire logic scl_out_i,
   output logic sda_line_o,
   output logic scl_line_o
);
   logic sda_low = 1'b0;
   logic scl_low = 1'b0;
   // Pulled-up open-drain lines: whoever pulls low wins
   assign sda_line_o = !(sda_low || (sda_oe_i && !sda_out_i));
   assign scl_line_o = !(scl_low || (scl_oe_i && !scl_out_i));
   // Start, then eight bits MSB first at 125 ns; the clock stands still between frames
   task automatic send(input logic [7:0] b);
      int w;
      sda_low = 1'b1;
      #62.5 scl_low = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         #31 sda_low = !b[i];
         #31.5 scl_low = 1'b0;
         w = 0;
         // Honour a held clock, but give up after 40 us
         while (!scl_line_o && w < 4000) begin
            #10 w++;
         end
         #62.5 scl_low = 1'b1;
      end
      // Let go of both lines; an overflow hold keeps the clock low until software frees it
      #31 sda_low = 1'b0;
      #31.5 scl_low = 1'b0;
   endtask
endmodule
